/* File: common/tdc_pkg.sv */
/*
 * Shared constants for the 10-bit down-counting timer with PWM.
 * Assumes a 32-bit APB slave where register n sits at byte address 4*n.
 */
package tdc_pkg;

	// Register indices; byte address is four times the index
	localparam logic [5:0] IDX_VALUE   = 6'h00;
	localparam logic [5:0] IDX_CONTROL = 6'h01;
	localparam logic [5:0] IDX_CLKCTL  = 6'h02;
	localparam logic [5:0] IDX_DUTY    = 6'h03;
	localparam logic [5:0] IDX_HIGH    = 6'h08;

	// down_counter_control fields
	localparam int BIT_RUN        = 0;
	localparam int BIT_RELOAD_SEL = 1;
	localparam int BIT_ONE_SHOT   = 2;
	localparam int BIT_TOG_ROUTE  = 5;
	localparam int BIT_ACT_LOW    = 6;
	localparam int BIT_PWM_ROUTE  = 7;
	localparam logic [7:0] CONTROL_MASK  = 8'hE7;
	localparam logic [7:0] CONTROL_RESET = 8'h00;

	// Clock control fields
	localparam int BIT_CLK_EDGE = 4;
	localparam int BIT_CLK_SEL  = 5;
	localparam logic [7:0] CLKCTL_MASK  = 8'h30;
	localparam logic [7:0] CLKCTL_RESET = 8'h30;

	// counter_high_bits fields
	localparam int HI_CNT_LSB  = 4;
	localparam int HI_DUTY_LSB = 0;
	localparam logic [7:0] HIGH_MASK  = 8'h33;
	localparam logic [7:0] HIGH_RESET = 8'h00;

	localparam logic [7:0] DUTY_RESET = 8'h00;

	// Counter values
	localparam logic [9:0] COUNT_MAX   = 10'h3FF;
	localparam logic [9:0] COUNT_ZERO  = 10'h000;
	localparam logic [9:0] COUNT_RESET = 10'h3FF;

endpackage : tdc_pkg

/* File: core/tdc_in_sync.sv */
/*
 * Three-stage input synchroniser with agreement filter and edge pulses.
 * Assumes the input is asynchronous to clk; ce freezes all state.
 */
`timescale 1ns/10ps
module tdc_in_sync (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic ce,
	// Raw input
	input  wire logic din,
	// Filtered level and edges
	output logic      level,
	output logic      rise,
	output logic      fall
);
	logic s1_r;
	logic s2_r;
	logic s3_r;
	logic lvl_r;
	logic rise_r;
	logic fall_r;

	// Change accepted only once stages two and three agree
	wire agree   = (s2_r == s3_r);
	wire lvl_nxt = agree ? s3_r : lvl_r;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_r   <= 1'b0;
			s2_r   <= 1'b0;
			s3_r   <= 1'b0;
			lvl_r  <= 1'b0;
			rise_r <= 1'b0;
			fall_r <= 1'b0;
		end else if (ce) begin
			s1_r   <= din;
			s2_r   <= s1_r;
			s3_r   <= s2_r;
			lvl_r  <= lvl_nxt;
			rise_r <= lvl_nxt & ~lvl_r;
			fall_r <= ~lvl_nxt & lvl_r;
		end
	end

	assign level = lvl_r;
	assign rise  = rise_r;
	assign fall  = fall_r;

endmodule : tdc_in_sync

/* File: core/tdc_timer.sv */
/*
 * 10-bit down-counting timer with one-shot and free-running reload,
 * PWM and underflow-toggle outputs on one shared port pin, APB slave.
 * Assumes a single 100 MHz pclk that acts as the instruction clock and
 * an asynchronous external count input.
 */
// Overview of operation
// - Reading the value register returns the live 10-bit down count.
// - Writing the value register loads byte plus two high bits into reload and count.
// - Counter decrements only while the run bit is set; otherwise holds.
// - Free-running, reload select clear: underflow from zero loads 0x3FF.
// - Free-running, reload select set: underflow loads the stored reload value.
// - One-shot: count down once to zero, then stop regardless of reload select.
// - Active-low bit set makes active PWM level low, clear makes it high.
// - PWM route bit drives PWM onto the shared pin; with neither route bit set the pin stays GPIO.
// - Toggle route bit drives a signal inverted on every underflow onto the pin.
// - When both outputs are routed, the toggle output wins the pin.
// - Reload sets PWM frame period; 10-bit duty from two high bits plus byte.
// - Clock select chooses instruction clock or external input edges to decrement.
`timescale 1ns/10ps
module tdc_timer #(
	parameter int ADDR_W = 8
) (
	// Clock, reset, enable
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              ce,
	// APB slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	// External count input
	input  wire logic              external_count_input,
	// Port logic for the shared pin when used as GPIO
	input  wire logic              gpio_out,
	input  wire logic              gpio_oe,
	// Shared port pin
	output logic                   shared_port_pin,
	output logic                   shared_port_pin_oe
);
	// Registers
	logic [7:0]  ctrl_r;
	logic [7:0]  clkctl_r;
	logic [7:0]  high_r;
	logic [7:0]  duty_r;
	logic [9:0]  count_r;
	logic [9:0]  count_nxt;
	logic [9:0]  reload_r;
	logic        stopped_r;
	logic        stopped_nxt;
	logic        toggle_r;
	logic [31:0] prdata_r;
	logic        pready_r;
	logic        pslverr_r;
	logic        pin_r;
	logic        pin_oe_r;

	// APB decode
	wire setup  = psel & ~penable;
	wire access = psel & penable & pready_r;
	wire aligned = (paddr[1:0] == 2'b00);
	wire [ADDR_W-3:0] idx = paddr[ADDR_W-1:2];
	wire hit_value = aligned & (idx == (ADDR_W-2)'(tdc_pkg::IDX_VALUE));
	wire hit_ctrl  = aligned & (idx == (ADDR_W-2)'(tdc_pkg::IDX_CONTROL));
	wire hit_clk   = aligned & (idx == (ADDR_W-2)'(tdc_pkg::IDX_CLKCTL));
	wire hit_duty  = aligned & (idx == (ADDR_W-2)'(tdc_pkg::IDX_DUTY));
	wire hit_high  = aligned & (idx == (ADDR_W-2)'(tdc_pkg::IDX_HIGH));
	wire mapped = hit_value | hit_ctrl | hit_clk | hit_duty | hit_high;
	wire wr_en  = ce & access & pwrite & mapped;
	wire wr_value = wr_en & hit_value;

	// Control fields
	wire run        = ctrl_r[tdc_pkg::BIT_RUN];
	wire reload_sel = ctrl_r[tdc_pkg::BIT_RELOAD_SEL];
	wire one_shot   = ctrl_r[tdc_pkg::BIT_ONE_SHOT];
	wire tog_route  = ctrl_r[tdc_pkg::BIT_TOG_ROUTE];
	wire act_low    = ctrl_r[tdc_pkg::BIT_ACT_LOW];
	wire pwm_route  = ctrl_r[tdc_pkg::BIT_PWM_ROUTE];
	wire clk_sel    = clkctl_r[tdc_pkg::BIT_CLK_SEL];
	wire clk_edge   = clkctl_r[tdc_pkg::BIT_CLK_EDGE];
	wire [1:0] hi_cnt  = high_r[tdc_pkg::HI_CNT_LSB +: 2];
	wire [1:0] hi_duty = high_r[tdc_pkg::HI_DUTY_LSB +: 2];
	wire [9:0] duty = {hi_duty, duty_r};
	wire [9:0] wr_load = {hi_cnt, pwdata[7:0]};

	// External count edges
	logic ext_rise;
	logic ext_fall;

	tdc_in_sync u_ext_sync (
		.clk   (pclk),
		.rst_n (presetn),
		.ce    (ce),
		.din   (external_count_input),
		.level (),
		.rise  (ext_rise),
		.fall  (ext_fall)
	);

	// Decrement source: every pclk, or the chosen external edge
	wire ext_tick = clk_edge ? ext_fall : ext_rise;
	wire tick     = clk_sel ? ext_tick : 1'b1;
	wire dec_en   = ce & run & tick & ~stopped_r & ~wr_value;
	wire at_zero  = (count_r == tdc_pkg::COUNT_ZERO);
	wire underflow = dec_en & at_zero;

	// Wrap value after underflow in free-running mode
	wire [9:0] wrap_val = reload_sel ? reload_r : tdc_pkg::COUNT_MAX;

	always_comb begin
		count_nxt   = count_r;
		stopped_nxt = stopped_r;
		if (wr_value) begin
			count_nxt   = wr_load;
			stopped_nxt = 1'b0;
		end else if (!run) begin
			// Clearing run re-arms a finished one-shot
			stopped_nxt = 1'b0;
		end else if (underflow) begin
			if (one_shot) begin
				stopped_nxt = 1'b1;
			end else begin
				count_nxt = wrap_val;
			end
		end else if (dec_en) begin
			count_nxt = count_r - 10'h001;
		end
	end

	// PWM: frame set by the reload period, active at or below duty
	wire pwm_active = (count_r <= duty);
	wire pwm_level  = pwm_active ^ act_low;

	// Pin selection; toggle output has priority
	wire pin_nxt    = tog_route ? toggle_r : (pwm_route ? pwm_level : gpio_out);
	wire pin_oe_nxt = (tog_route | pwm_route) ? 1'b1 : gpio_oe;

	// Read mux; narrow registers sit in the low bits
	wire [31:0] rd_nxt = hit_value ? {22'h000000, count_r} :
	                     hit_ctrl  ? {24'h000000, ctrl_r} :
	                     hit_clk   ? {24'h000000, clkctl_r} :
	                     hit_duty  ? {24'h000000, duty_r} :
	                     hit_high  ? {24'h000000, high_r} : 32'h00000000;

	// Bus slave: read data captured in the setup cycle, zero wait states
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r  <= 32'h00000000;
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
		end else if (ce) begin
			pready_r <= 1'b1;
			if (setup) begin
				prdata_r  <= pwrite ? 32'h00000000 : rd_nxt;
				pslverr_r <= ~mapped;
			end
		end
	end

	// Software registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r   <= tdc_pkg::CONTROL_RESET;
			clkctl_r <= tdc_pkg::CLKCTL_RESET;
			high_r   <= tdc_pkg::HIGH_RESET;
			duty_r   <= tdc_pkg::DUTY_RESET;
			reload_r <= tdc_pkg::COUNT_RESET;
		end else if (wr_en) begin
			if (hit_ctrl) begin
				ctrl_r <= pwdata[7:0] & tdc_pkg::CONTROL_MASK;
			end
			if (hit_clk) begin
				clkctl_r <= pwdata[7:0] & tdc_pkg::CLKCTL_MASK;
			end
			if (hit_high) begin
				high_r <= pwdata[7:0] & tdc_pkg::HIGH_MASK;
			end
			if (hit_duty) begin
				duty_r <= pwdata[7:0];
			end
			if (hit_value) begin
				reload_r <= wr_load;
			end
		end
	end

	// Counter, one-shot state, toggle and pin
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_r   <= tdc_pkg::COUNT_RESET;
			stopped_r <= 1'b0;
			toggle_r  <= 1'b0;
			pin_r     <= 1'b0;
			pin_oe_r  <= 1'b0;
		end else if (ce) begin
			count_r   <= count_nxt;
			stopped_r <= stopped_nxt;
			toggle_r  <= toggle_r ^ underflow;
			pin_r     <= pin_nxt;
			pin_oe_r  <= pin_oe_nxt;
		end
	end

	assign prdata             = prdata_r;
	assign pready             = pready_r;
	assign pslverr            = pslverr_r;
	assign shared_port_pin    = pin_r;
	assign shared_port_pin_oe = pin_oe_r;

	// Checks
	property p_read_value;
		@(posedge pclk) disable iff (!presetn)
		ce & setup & ~pwrite & hit_value |=> prdata == {22'h000000, $past(count_r)};
	endproperty
	a_read_value: assert property (p_read_value)
		else $error("value read does not return live count");

	property p_write_load;
		@(posedge pclk) disable iff (!presetn)
		wr_value |=> (count_r == $past(wr_load)) && (reload_r == $past(wr_load));
	endproperty
	a_write_load: assert property (p_write_load)
		else $error("value write did not load count and reload");

	property p_hold_idle;
		@(posedge pclk) disable iff (!presetn)
		ce & ~run & ~wr_value |=> $stable(count_r);
	endproperty
	a_hold_idle: assert property (p_hold_idle)
		else $error("count moved while run clear");

	property p_wrap_max;
		@(posedge pclk) disable iff (!presetn)
		underflow & ~one_shot & ~reload_sel |=> count_r == 10'h3FF;
	endproperty
	a_wrap_max: assert property (p_wrap_max)
		else $error("underflow did not wrap to maximum");

	property p_wrap_reload;
		@(posedge pclk) disable iff (!presetn)
		underflow & ~one_shot & reload_sel |=> count_r == $past(reload_r);
	endproperty
	a_wrap_reload: assert property (p_wrap_reload)
		else $error("underflow did not take reload value");

	property p_one_shot_stop;
		@(posedge pclk) disable iff (!presetn)
		underflow & one_shot ##1 (ce & run & ~wr_value) [*2] |-> count_r == 10'h000 && stopped_r;
	endproperty
	a_one_shot_stop: assert property (p_one_shot_stop)
		else $error("one-shot kept counting after underflow");

	property p_toggle_flip;
		@(posedge pclk) disable iff (!presetn)
		underflow |=> toggle_r != $past(toggle_r);
	endproperty
	a_toggle_flip: assert property (p_toggle_flip)
		else $error("toggle output did not follow underflow");

	// Toggle state must only move on an underflow, never on a stray tick
	property p_toggle_hold;
		@(posedge pclk) disable iff (!presetn)
		ce & ~underflow |=> $stable(toggle_r);
	endproperty
	a_toggle_hold: assert property (p_toggle_hold)
		else $error("toggle output moved without underflow");

	property p_toggle_pin;
		@(posedge pclk) disable iff (!presetn)
		ce & tog_route |=> shared_port_pin_oe && shared_port_pin == $past(toggle_r);
	endproperty
	a_toggle_pin: assert property (p_toggle_pin)
		else $error("toggle output not driven on the pin");

	property p_toggle_wins;
		@(posedge pclk) disable iff (!presetn)
		ce & tog_route & pwm_route |=> shared_port_pin == $past(toggle_r) && shared_port_pin_oe;
	endproperty
	a_toggle_wins: assert property (p_toggle_wins)
		else $error("PWM took the pin from the toggle output");

	property p_pwm_level;
		@(posedge pclk) disable iff (!presetn)
		ce & pwm_route & ~tog_route |=> shared_port_pin_oe &&
			(shared_port_pin == (($past(count_r) <= $past(duty)) ^ $past(act_low)));
	endproperty
	a_pwm_level: assert property (p_pwm_level)
		else $error("PWM pin level wrong for count and duty");

	property p_gpio_pass;
		@(posedge pclk) disable iff (!presetn)
		ce & ~pwm_route & ~tog_route |=> shared_port_pin == $past(gpio_out) && shared_port_pin_oe == $past(gpio_oe);
	endproperty
	a_gpio_pass: assert property (p_gpio_pass)
		else $error("pin not returned to port logic");

	property p_ext_hold;
		@(posedge pclk) disable iff (!presetn)
		ce & clk_sel & ~ext_tick & ~wr_value & ~underflow |=> $stable(count_r);
	endproperty
	a_ext_hold: assert property (p_ext_hold)
		else $error("count moved without external edge");

	property p_count_step;
		@(posedge pclk) disable iff (!presetn)
		ce & run & ~clk_sel & ~stopped_r & ~at_zero & ~wr_value |=> count_r == $past(count_r) - 10'h001;
	endproperty
	a_count_step: assert property (p_count_step)
		else $error("count did not step on instruction clock");

	// Catches an external edge tick that does not step the count down by exactly one
	property p_ext_step;
		@(posedge pclk) disable iff (!presetn)
		ce & run & clk_sel & ext_tick & ~stopped_r & ~at_zero & ~wr_value |=> count_r == $past(count_r) - 10'h001;
	endproperty
	a_ext_step: assert property (p_ext_step)
		else $error("count did not step on external edge");

	property p_stop_hold;
		@(posedge pclk) disable iff (!presetn)
		ce & stopped_r & run & ~wr_value |=> stopped_r && $stable(count_r);
	endproperty
	a_stop_hold: assert property (p_stop_hold)
		else $error("finished one-shot started again");

	property p_rearm;
		@(posedge pclk) disable iff (!presetn)
		ce & (~run | wr_value) |=> ~stopped_r;
	endproperty
	a_rearm: assert property (p_rearm)
		else $error("one-shot not re-armed");

	property p_stop_one_shot;
		@(posedge pclk) disable iff (!presetn)
		ce & ~stopped_r & ~(underflow & one_shot) |=> ~stopped_r;
	endproperty
	a_stop_one_shot: assert property (p_stop_one_shot)
		else $error("counter stopped outside one-shot underflow");

endmodule : tdc_timer

/* File: sim/testbench.sv */
/*
 * Self-checking bench for the down-counting timer: APB reads queued and
 * scored by a monitor, pin behaviour measured directly.
 * Assumes zero-wait APB slave and the register map of the package.
 */
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin miscompares++; \
	$display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
module testbench;
	localparam logic [7:0] A_VAL = {tdc_pkg::IDX_VALUE, 2'b00};
	localparam logic [7:0] A_CTL = {tdc_pkg::IDX_CONTROL, 2'b00};
	localparam logic [7:0] A_CLK = {tdc_pkg::IDX_CLKCTL, 2'b00};
	localparam logic [7:0] A_DUT = {tdc_pkg::IDX_DUTY, 2'b00};
	localparam logic [7:0] A_HI  = {tdc_pkg::IDX_HIGH, 2'b00};
	logic        pclk, presetn, ce, psel, penable, pwrite, ext_in, gpio_out, gpio_oe;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata;
	logic        pready, pslverr, pin_o, pin_oe;
	logic [32:0] exp_q[$];
	int          miscompares, cmp_count, seed, n, i;
	logic [9:0]  v;
	logic [7:0]  c;

	tdc_timer #(.ADDR_W(8)) tdc_timer_inst (
		.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .external_count_input(ext_in),
		.gpio_out(gpio_out), .gpio_oe(gpio_oe), .shared_port_pin(pin_o),
		.shared_port_pin_oe(pin_oe));

	always #5 pclk = ~pclk;

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 1'b0; penable <= 1'b0;
	endtask : apb

	// Note the expected answer before the read goes out
	task automatic rd(input logic [7:0] a, input logic [32:0] ex);
		exp_q.push_back(ex);
		apb(1'b0, a, 32'h0);
	endtask : rd

	// Stop, then load a 10-bit value through the high bits and value register
	task automatic load(input logic [9:0] val);
		apb(1'b1, A_CTL, 32'h0);
		apb(1'b1, A_HI, {26'h0, val[9:8], 4'h0});
		apb(1'b1, A_VAL, {24'h0, val[7:0]});
	endtask : load

	// Cycles between two successive changes of the pin value
	task automatic interval(output int cnt);
		logic last;
		cnt = 0;
		// Let the route change settle so only underflow edges are timed
		repeat (3) @(posedge pclk);
		last = pin_o;
		do @(posedge pclk); while (pin_o === last);
		last = pin_o;
		do begin @(posedge pclk); cnt++; end while (pin_o === last);
	endtask : interval

	always @(posedge pclk) begin
		if (psel && penable && pready && !pwrite) begin
			if (exp_q.size() == 0) begin
				miscompares++;
				$display("[FAIL] read with no expectation");
			end else begin
				`CHK("read data", exp_q.pop_front(), {pslverr, prdata})
			end
		end
	end

	task automatic results;
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : results

	initial begin
		repeat (60000) @(posedge pclk);
		miscompares++;
		results();
	end

	initial begin
		pclk = 0; presetn = 0; ce = 1; psel = 0; penable = 0; pwrite = 0;
		paddr = 0; pwdata = 0; ext_in = 0; gpio_out = 0; gpio_oe = 0;
		seed = 36901;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		rd(A_CTL, {1'b0, 24'h0, tdc_pkg::CONTROL_RESET});
		rd(A_VAL, {1'b0, 22'h0, tdc_pkg::COUNT_RESET});
		rd(8'h10, {1'b1, 32'h0}); // Unmapped place answers with an error
		apb(1'b1, A_CLK, 32'h0);
		for (i = 0; i < 4; i++) begin
			c = $random(seed);
			apb(1'b1, A_CTL, {24'h0, c});
			rd(A_CTL, {1'b0, 24'h0, c & tdc_pkg::CONTROL_MASK});
			v = $random(seed);
			load(v);
			repeat (5) @(posedge pclk);
			rd(A_VAL, {1'b0, 22'h0, v});
			gpio_out <= $random(seed);
			gpio_oe <= $random(seed);
			repeat (3) @(posedge pclk);
			`CHK("gpio pin", {gpio_oe, gpio_out}, {pin_oe, pin_o})
		end
		$display("registers done");
		load(10'h005);
		apb(1'b1, A_CTL, 32'h27);
		repeat (20) @(posedge pclk);
		rd(A_VAL, {1'b0, 22'h0, tdc_pkg::COUNT_ZERO});
		$display("one-shot done");
		load(10'h005);
		apb(1'b1, A_CTL, 32'h23);
		interval(n);
		`CHK("reload period", 6, n)
		`CHK("toggle drive", 1'b1, pin_oe)
		load(10'h005);
		apb(1'b1, A_CTL, 32'h21);
		interval(n);
		`CHK("wrap period", 1024, n)
		$display("free-run done");
		for (i = 0; i < 2; i++) begin
			load(10'h009);
			apb(1'b1, A_DUT, 32'h03);
			apb(1'b1, A_CTL, i ? 32'hC3 : 32'h83);
			repeat (3) @(posedge pclk);
			n = 0;
			repeat (100) begin @(posedge pclk); n += pin_o; end
			`CHK("pwm high cycles", i ? 60 : 40, n)
			`CHK("pwm drive", 1'b1, pin_oe)
		end
		apb(1'b1, A_CTL, 32'hA3);
		interval(n);
		`CHK("both routed period", 10, n)
		$display("pwm done");
		for (i = 0; i < 2; i++) begin
			load(10'h010);
			apb(1'b1, A_CLK, i ? 32'h30 : 32'h20);
			apb(1'b1, A_CTL, 32'h01);
			repeat (3) begin
				@(posedge pclk) ext_in <= 1'b1;
				repeat (6) @(posedge pclk);
				ext_in <= 1'b0;
				repeat (6) @(posedge pclk);
			end
			repeat (8) @(posedge pclk);
			rd(A_VAL, {1'b0, 22'h0, 10'h00D});
		end
		$display("external clock done");
		load(10'h100);
		apb(1'b1, A_CLK, 32'h0);
		apb(1'b1, A_CTL, 32'h01);
		ce <= 1'b0;
		repeat (20) @(posedge pclk);
		ce <= 1'b1;
		rd(A_VAL, {1'b0, 22'h0, 10'h0FF});
		$display("clock enable done");
		results();
	end
endmodule : testbench
